// *** verilog/csd_host_ctrl.sv ***
/*
 * csd_host_ctrl: host side controller for a removable card's parallel port.
 * Software loads address, data and a command over APB; the block runs one
 * framed strobe cycle on the card pins and reports the result.
 * Assumes the card answers within the strobe width; no wait pin is used.
 */
// Decided for this implementation: the register offsets and the APB slave port.
// Functional notes
// - attribute read keeps select, output enable low
// - strobes released between consecutive cycles
// - attribute writes only to config registers
// - config base loaded by software, not fixed
`timescale 1ns/1ps
module csd_host_ctrl (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [csd_pkg::APB_AW-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    output csd_pkg::csd_pins_t               cardPins,
    input  wire logic [csd_pkg::CARD_DW-1:0] cardDataIn,
    output logic      [csd_pkg::CARD_DW-1:0] cardDataOut,
    output logic      [1:0]                  cardDataOe
);
    csd_pkg::csd_state_t                   state;
    logic [csd_pkg::CNT_W-1:0]             phaseCnt;
    logic [csd_pkg::CARD_AW-1:0]           addrReg;
    logic [csd_pkg::CARD_DW-1:0]           wdataReg;
    logic [csd_pkg::CARD_DW-1:0]           rdataReg;
    logic [csd_pkg::CARD_AW-1:0]           cfgBase;
    logic                                  cmdWrite;
    logic                                  cmdAttr;
    logic [1:0]                            cmdLane;
    logic                                  doneFlag;
    logic                                  refusedFlag;
    logic [csd_pkg::CARD_DW-1:0]           dataMeta;
    logic [csd_pkg::CARD_DW-1:0]           dataSync;
    logic                                  apbWrite;
    logic                                  apbSetup;
    logic                                  mapped;
    logic                                  goReq;
    logic                                  reqWrite;
    logic                                  reqAttr;
    logic [1:0]                            reqLane;
    logic                                  reqBad;
    logic                                  phaseEnd;
    logic [csd_pkg::CARD_AW-1:0]           cfgOffset;

    // apb decode; slave never stalls
    assign apbWrite = psel & penable & pwrite;
    assign apbSetup = psel & ~penable;
    assign pready   = 1'b1;
    assign mapped   = (paddr == csd_pkg::OFS_CTRL) || (paddr == csd_pkg::OFS_ADDR)
                   || (paddr == csd_pkg::OFS_WDATA) || (paddr == csd_pkg::OFS_RDATA)
                   || (paddr == csd_pkg::OFS_STATUS) || (paddr == csd_pkg::OFS_CFGBASE);
    assign pslverr  = psel & penable & ~mapped;

    // command fields straight from the write data of a go write
    assign goReq    = apbWrite && (paddr == csd_pkg::OFS_CTRL) && pwdata[csd_pkg::CTRL_GO];
    assign reqWrite = pwdata[csd_pkg::CTRL_WRITE];
    assign reqAttr  = pwdata[csd_pkg::CTRL_ATTR];
    assign reqLane  = pwdata[csd_pkg::CTRL_LANE +: 2];

    // offset wraps below cfgBase, so the lower bound is tested apart
    assign cfgOffset = addrReg - cfgBase;

    // refusal check before any pin moves, so a bad access never reaches the card
    always_comb begin
        reqBad = (reqLane == csd_pkg::LANE_NONE);
        if (reqAttr) begin
            if (reqLane == csd_pkg::LANE_HIGH || addrReg[0]) begin
                reqBad = 1'b1;
            end
            // writes outside the config window would hit card info or reserved space
            if (reqWrite && (addrReg < cfgBase || cfgOffset >= csd_pkg::CFG_WIN_SPAN)) begin
                reqBad = 1'b1;
            end
        end
    end

    // apb read data registered in the setup phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (apbSetup) begin
            unique case (paddr)
                csd_pkg::OFS_CTRL:    prdata <= {27'h0, cmdLane, cmdAttr, cmdWrite, 1'b0};
                csd_pkg::OFS_ADDR:    prdata <= {21'h0, addrReg};
                csd_pkg::OFS_WDATA:   prdata <= {16'h0, wdataReg};
                csd_pkg::OFS_RDATA:   prdata <= {16'h0, rdataReg};
                csd_pkg::OFS_STATUS:  prdata <= {29'h0, refusedFlag, doneFlag,
                                                 state != csd_pkg::CSD_IDLE};
                csd_pkg::OFS_CFGBASE: prdata <= {21'h0, cfgBase};
                default:              prdata <= 32'h0000_0000;
            endcase
        end
    end

    // address, data and config base; locked while a cycle runs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            addrReg  <= '0;
            wdataReg <= '0;
            cfgBase  <= csd_pkg::CFGBASE_RESET;
        end else if (apbWrite && state == csd_pkg::CSD_IDLE) begin
            if (paddr == csd_pkg::OFS_ADDR) begin
                addrReg <= pwdata[csd_pkg::CARD_AW-1:0];
            end
            if (paddr == csd_pkg::OFS_WDATA) begin
                wdataReg <= pwdata[csd_pkg::CARD_DW-1:0];
            end
            if (paddr == csd_pkg::OFS_CFGBASE) begin
                cfgBase <= pwdata[csd_pkg::CARD_AW-1:0];
            end
        end
    end

    // latched command
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdWrite <= 1'b0;
            cmdAttr  <= 1'b0;
            cmdLane  <= csd_pkg::LANE_NONE;
        end else if (goReq && state == csd_pkg::CSD_IDLE) begin
            cmdWrite <= reqWrite;
            cmdAttr  <= reqAttr;
            cmdLane  <= reqLane;
        end
    end

    // sticky flags: set beats a write-one clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            doneFlag    <= 1'b0;
            refusedFlag <= 1'b0;
        end else begin
            if (state == csd_pkg::CSD_RECOVER && phaseEnd) begin
                doneFlag <= 1'b1;
            end else if (apbWrite && paddr == csd_pkg::OFS_STATUS && pwdata[csd_pkg::STAT_DONE]) begin
                doneFlag <= 1'b0;
            end
            // refused rises at the go edge; no pin moves for it
            if (goReq && state == csd_pkg::CSD_IDLE && reqBad) begin
                refusedFlag <= 1'b1;
            end else if (apbWrite && paddr == csd_pkg::OFS_STATUS && pwdata[csd_pkg::STAT_REFUSED]) begin
                refusedFlag <= 1'b0;
            end
        end
    end

    // two-flop synchroniser for the card data pins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataMeta <= '0;
            dataSync <= '0;
        end else begin
            // dataMeta may go metastable; nothing else reads it
            dataMeta <= cardDataIn;
            dataSync <= dataMeta;
        end
    end

    // phase length in cycles
    always_comb begin
        // counts rounded up to whole ref_clk periods
        unique case (state)
            csd_pkg::CSD_SETUP:   phaseEnd = (phaseCnt == csd_pkg::CNT_W'(csd_pkg::SETUP_CYC - 1));
            csd_pkg::CSD_STROBE:  phaseEnd = (phaseCnt == csd_pkg::CNT_W'(csd_pkg::STROBE_CYC - 1));
            csd_pkg::CSD_HOLD:    phaseEnd = (phaseCnt == csd_pkg::CNT_W'(csd_pkg::HOLD_CYC - 1));
            csd_pkg::CSD_RECOVER: phaseEnd = (phaseCnt == csd_pkg::CNT_W'(csd_pkg::RECOVER_CYC - 1));
            default:              phaseEnd = 1'b0;
        endcase
    end

    // cycle sequencer: setup, strobe, hold, then a recovery with all pins idle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= csd_pkg::CSD_IDLE;
            phaseCnt <= '0;
        end else begin
            unique case (state)
                csd_pkg::CSD_IDLE: begin
                    phaseCnt <= '0;
                    // a refused go stays idle
                    if (goReq && !reqBad) begin
                        state <= csd_pkg::CSD_SETUP;
                    end
                end
                csd_pkg::CSD_SETUP: begin
                    phaseCnt <= phaseEnd ? '0 : phaseCnt + 1'b1;
                    if (phaseEnd) begin
                        state <= csd_pkg::CSD_STROBE;
                    end
                end
                csd_pkg::CSD_STROBE: begin
                    phaseCnt <= phaseEnd ? '0 : phaseCnt + 1'b1;
                    if (phaseEnd) begin
                        state <= csd_pkg::CSD_HOLD;
                    end
                end
                csd_pkg::CSD_HOLD: begin
                    phaseCnt <= phaseEnd ? '0 : phaseCnt + 1'b1;
                    if (phaseEnd) begin
                        state <= csd_pkg::CSD_RECOVER;
                    end
                end
                csd_pkg::CSD_RECOVER: begin
                    phaseCnt <= phaseEnd ? '0 : phaseCnt + 1'b1;
                    if (phaseEnd) begin
                        state <= csd_pkg::CSD_IDLE;
                    end
                end
                default: begin
                    state    <= csd_pkg::CSD_IDLE;
                    phaseCnt <= '0;
                end
            endcase
        end
    end

    // read data taken at the last strobe cycle; sync delay is inside the strobe width
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdataReg <= '0;
        end else if (state == csd_pkg::CSD_STROBE && phaseEnd && !cmdWrite) begin
            if (cmdAttr) begin
                rdataReg <= {8'h00, dataSync[7:0]};
            end else begin
                // high-only reads land in the low byte of RDATA
                unique case (cmdLane)
                    csd_pkg::LANE_HIGH: rdataReg <= {8'h00, dataSync[15:8]};
                    csd_pkg::LANE_WORD: rdataReg <= dataSync;
                    default:            rdataReg <= {8'h00, dataSync[7:0]};
                endcase
            end
        end
    end

    // card pins; outside setup..hold both enables stay high (standby)
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cardPins <= csd_pkg::PINS_IDLE;
        end else if ((state == csd_pkg::CSD_IDLE && goReq && !reqBad)
                     || state == csd_pkg::CSD_SETUP || state == csd_pkg::CSD_STROBE
                     || (state == csd_pkg::CSD_HOLD && !phaseEnd)) begin
            // attribute space always uses the low enable; word mode adds the high one
            cardPins.lowByteEnableN  <= !(state == csd_pkg::CSD_IDLE ? reqLane[0] | reqAttr
                                                                     : cmdLane[0] | cmdAttr);
            cardPins.highByteEnableN <= !(state == csd_pkg::CSD_IDLE ? reqLane[1] : cmdLane[1]);
            cardPins.attrSelN        <= !(state == csd_pkg::CSD_IDLE ? reqAttr : cmdAttr);
            // word access puts A0 low so the even byte leads
            cardPins.addr            <= {addrReg[csd_pkg::CARD_AW-1:1],
                                         addrReg[0] & ~((state == csd_pkg::CSD_IDLE ? reqLane : cmdLane)
                                                        == csd_pkg::LANE_WORD)};
            // strobe spans the last setup edge to the last strobe edge
            cardPins.outEnN          <= !(state == csd_pkg::CSD_SETUP && phaseEnd && !cmdWrite
                                          || state == csd_pkg::CSD_STROBE && !(phaseEnd || cmdWrite));
            cardPins.wrStrobeN       <= !(state == csd_pkg::CSD_SETUP && phaseEnd && cmdWrite
                                          || state == csd_pkg::CSD_STROBE && !phaseEnd && cmdWrite);
        end else begin
            cardPins <= csd_pkg::PINS_IDLE;
        end
    end

    // write data lanes; attribute writes drive only the even byte
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cardDataOut <= '0;
            cardDataOe  <= 2'h0;
        end else if (cmdWrite && (state == csd_pkg::CSD_SETUP || state == csd_pkg::CSD_STROBE
                                  || (state == csd_pkg::CSD_HOLD && !phaseEnd))) begin
            if (cmdAttr) begin
                cardDataOut <= {8'h00, wdataReg[7:0]};
                cardDataOe  <= 2'h1;
            end else if (cmdLane == csd_pkg::LANE_HIGH) begin
                cardDataOut <= {wdataReg[7:0], 8'h00};
                cardDataOe  <= 2'h2;
            end else begin
                // one enable bit per byte lane
                cardDataOut <= wdataReg;
                cardDataOe  <= cmdLane;
            end
        end else begin
            cardDataOut <= '0;
            cardDataOe  <= 2'h0;
        end
    end
endmodule : csd_host_ctrl

// *** verilog/csd_pkg.sv ***
/*
 * csd_pkg: constants and types for the card space host controller.
 * Assumes a 25 MHz ref_clk and an APB register port with byte offsets.
 */
package csd_pkg;
    // card pin widths and the apb address width
    localparam int CARD_AW = 11;
    localparam int CARD_DW = 16;
    localparam int APB_AW  = 8;

    // own register map, byte offsets, one word each
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_ADDR    = 8'h04;
    localparam logic [7:0] OFS_WDATA   = 8'h08;
    localparam logic [7:0] OFS_RDATA   = 8'h0c;
    localparam logic [7:0] OFS_STATUS  = 8'h10;
    localparam logic [7:0] OFS_CFGBASE = 8'h14;

    // control fields
    localparam int CTRL_GO    = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_ATTR  = 2;
    localparam int CTRL_LANE  = 3;   // two bits
    localparam logic [1:0] LANE_NONE = 2'h0;
    localparam logic [1:0] LANE_LOW  = 2'h1;
    localparam logic [1:0] LANE_HIGH = 2'h2;
    localparam logic [1:0] LANE_WORD = 2'h3;

    // status fields
    localparam int STAT_BUSY    = 0;
    localparam int STAT_DONE    = 1;
    localparam int STAT_REFUSED = 2;

    // configuration register window: four byte registers on even addresses
    localparam logic [CARD_AW-1:0] CFGBASE_RESET = 11'h000;
    localparam logic [CARD_AW-1:0] CFG_WIN_SPAN  = 11'h008;

    // strobe timing, in ns and in ref_clk cycles (least times round up)
    localparam int CLK_NS     = 40;
    localparam int SETUP_NS   = 80;
    localparam int STROBE_NS  = 200;
    localparam int HOLD_NS    = 40;
    localparam int RECOVER_NS = 80;
    localparam int SETUP_CYC   = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC    = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W       = 4;

    typedef enum logic [2:0] {
        CSD_IDLE    = 3'b000,
        CSD_SETUP   = 3'b001,
        CSD_STROBE  = 3'b010,
        CSD_HOLD    = 3'b011,
        CSD_RECOVER = 3'b100
    } csd_state_t;

    // strobe and address pins toward the card, all active low strobes
    typedef struct packed {
        logic               highByteEnableN;
        logic               lowByteEnableN;
        logic               attrSelN;
        logic               outEnN;
        logic               wrStrobeN;
        logic [CARD_AW-1:0] addr;
    } csd_pins_t;

    localparam csd_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 11'h000};
endpackage : csd_pkg

// *** testbench/csd_host_sva.sv ***
/*
 * csd_host_sva: port checks on the card space host controller.
 * Assumes csd_pkg is compiled first; bound into every csd_host_ctrl.
 */
`timescale 1ns/1ps
module csd_host_sva (
    input wire logic                       ref_clk,
    input wire logic                       rst_n,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic [csd_pkg::APB_AW-1:0] paddr,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input csd_pkg::csd_pins_t              cardPins,
    input wire logic [1:0]                 cardDataOe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // selected lanes, 1 = enable active
    wire logic [1:0] laneOn = {~cardPins.highByteEnableN, ~cardPins.lowByteEnableN};
    // one cycle of an attribute read strobe, write strobe kept off
    sequence s_attrRead;
        !cardPins.attrSelN && !cardPins.outEnN && cardPins.wrStrobeN;
    endsequence
    // card fully idle: the gap that frames two cycles
    sequence s_idle;
        laneOn == 2'b00 && cardPins.outEnN && cardPins.wrStrobeN;
    endsequence
    a_apb_zero_wait: assert property (psel && penable |-> pready)
        else $error("apb access without ready");
    a_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h14))
        else $error("apb error flag wrong");
    a_standby_quiet: assert property (laneOn == 2'b00 |-> cardPins.outEnN && cardPins.wrStrobeN && cardDataOe == 2'b00)
        else $error("strobe or drive while card in standby");
    a_one_strobe: assert property (cardPins.outEnN || cardPins.wrStrobeN)
        else $error("read and write strobes low together");
    a_attr_even_low: assert property (!cardPins.attrSelN && laneOn != 2'b00 |-> laneOn[0] && !cardPins.addr[0])
        else $error("attribute access odd or high lane only");
    a_attr_read_hold: assert property ($fell(cardPins.outEnN) && !cardPins.attrSelN |-> s_attrRead [*5])
        else $error("attribute read strobe not held");
    a_frame_gap: assert property ($rose(cardPins.outEnN) || $rose(cardPins.wrStrobeN) |-> ##[0:2] s_idle [*2])
        else $error("no idle gap after card cycle");
    a_cis_no_write: assert property (!cardPins.wrStrobeN && !cardPins.attrSelN |-> cardPins.addr[10:9] != 2'b00)
        else $error("write strobe into card info region");
    a_attr_low_lane: assert property (!cardPins.wrStrobeN && !cardPins.attrSelN |-> cardDataOe == 2'b01)
        else $error("attribute write drives upper byte");
    a_common_lanes: assert property (!cardPins.wrStrobeN && cardPins.attrSelN |-> cardDataOe == laneOn)
        else $error("common write lanes differ from enables");
    a_read_released: assert property (!cardPins.outEnN |-> cardDataOe == 2'b00)
        else $error("host drives data during read");
    a_word_even: assert property (cardPins.attrSelN && laneOn == 2'b11 && !cardPins.outEnN |-> !cardPins.addr[0])
        else $error("word access at odd address");
endmodule : csd_host_sva

bind csd_host_ctrl csd_host_sva u_sva (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .cardPins(cardPins), .cardDataOe(cardDataOe)
);

// *** testbench/csd_card_model.sv ***
/*
 * csd_card_model: behavioural card answering the host controller's pins.
 * Assumes active low strobe levels and one host data enable per lane.
 */
`timescale 1ns/1ps
module csd_card_model (
    input wire logic          ref_clk,
    input csd_pkg::csd_pins_t cardPins,
    input wire logic [15:0]   cardDataOut,
    input wire logic [1:0]    cardDataOe,
    output logic [15:0]       cardDataIn
);
    logic [7:0]       cfgReg [4];
    logic [7:0]       mem [64];
    logic [15:0]      drive;
    logic [15:0]      junk = 16'h5a3c;
    wire logic [10:0] a      = cardPins.addr;
    wire logic        lowOn  = !cardPins.lowByteEnableN;
    wire logic        highOn = !cardPins.highByteEnableN;
    wire logic        attr   = !cardPins.attrSelN;
    wire logic        cfgHit = attr && lowOn && a[10:9] == 2'b01 && a[8:3] == 6'h00 && !a[0];
    wire logic        bad    = attr && ((lowOn && a[0]) || (highOn && !lowOn));
    initial begin
        foreach (cfgReg[i]) cfgReg[i] = 8'h00;
        foreach (mem[i]) mem[i] = 8'h00;
    end
    // no pull-ups: a floating lane shows a pattern that flips every cycle
    always @(posedge ref_clk) junk <= ~junk;
    // read data; standby or refused access leaves lanes floating
    always_comb begin
        drive = junk;
        if (!cardPins.outEnN && !bad) begin
            if (attr) begin
                drive[7:0] = cfgHit ? cfgReg[a[2:1]] : (a[10:9] == 2'b00 ? a[8:1] ^ 8'ha5 : 8'h00);
            end else begin
                if (lowOn) drive[7:0] = mem[a[5:0]];
                if (highOn) drive[15:8] = mem[{a[5:1], 1'b1}];
            end
        end
    end
    // host enable wins per lane, otherwise card data or float
    assign cardDataIn[7:0]  = cardDataOe[0] ? cardDataOut[7:0] : drive[7:0];
    assign cardDataIn[15:8] = cardDataOe[1] ? cardDataOut[15:8] : drive[15:8];
    // stores follow the strobe; card info and odd attribute writes are dropped
    always @(posedge ref_clk) begin
        if (!cardPins.wrStrobeN && !bad) begin
            if (cfgHit) cfgReg[a[2:1]] <= cardDataIn[7:0];
            else if (!attr && lowOn) mem[a[5:0]] <= cardDataIn[7:0];
            if (!attr && highOn) mem[{a[5:1], 1'b1}] <= cardDataIn[15:8];
        end
    end
endmodule : csd_card_model

// *** testbench/tb.sv ***
/*
 * tb: self-checking bench for csd_host_ctrl against the card model.
 * Assumes zero wait APB answers may still come late; every wait is bounded.
 */
`timescale 1ns/1ps
module tb;
    logic               ref_clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    csd_pkg::csd_pins_t cardPins;
    logic [15:0]        cardDataIn;
    logic [15:0]        cardDataOut;
    logic [1:0]         cardDataOe;
    logic [31:0]        rd;
    logic               e;
    int                 fails = 0;
    int                 n_compared = 0;

    csd_host_ctrl DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cardPins(cardPins), .cardDataIn(cardDataIn), .cardDataOut(cardDataOut), .cardDataOe(cardDataOe));
    csd_card_model card (.ref_clk(ref_clk), .cardPins(cardPins), .cardDataOut(cardDataOut),
        .cardDataOe(cardDataOe), .cardDataIn(cardDataIn));

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer; request held until ready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rdv,
                       output logic err);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fails++;
            print_verdict();
        end
    endtask : apb

    // one card cycle: load, go, poll status, clear flags, fetch read data
    task automatic card_op(input logic wr, input logic attr, input logic [1:0] lane, input logic [10:0] ad,
                           input logic [15:0] wd, input logic expRef, output logic [31:0] rdv);
        logic [31:0] st;
        logic        er;
        int          n;
        n = 0;
        apb(1'b1, csd_pkg::OFS_ADDR, {21'h0, ad}, st, er);
        apb(1'b1, csd_pkg::OFS_WDATA, {16'h0, wd}, st, er);
        apb(1'b1, csd_pkg::OFS_CTRL, {27'h0, lane, attr, wr, 1'b1}, st, er);
        do begin
            apb(1'b0, csd_pkg::OFS_STATUS, 32'h0, st, er);
            n++;
        end while (st[2:1] === 2'b00 && n < 40);
        if (n >= 40) begin
            fails++;
            print_verdict();
        end
        chk("status flags", {29'h0, expRef, !expRef, 1'b0}, {29'h0, st[2:0]});
        apb(1'b1, csd_pkg::OFS_STATUS, 32'h6, st, er);
        apb(1'b0, csd_pkg::OFS_RDATA, 32'h0, rdv, er);
    endtask : card_op

    // status reset value, an unmapped address, and the configuration base
    task automatic t_registers;
        apb(1'b0, csd_pkg::OFS_STATUS, 32'h0, rd, e);
        chk("status after reset", 32'h0, rd);
        apb(1'b0, 8'h40, 32'h0, rd, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        apb(1'b1, csd_pkg::OFS_ADDR, 32'hffff_ffff, rd, e);
        apb(1'b0, csd_pkg::OFS_ADDR, 32'h0, rd, e);
        chk("address register", 32'h7ff, rd);
        chk("mapped error", 32'h0, {31'h0, e});
        apb(1'b1, csd_pkg::OFS_CFGBASE, 32'h200, rd, e);
        apb(1'b0, csd_pkg::OFS_CFGBASE, 32'h0, rd, e);
        chk("config base", 32'h200, rd);
    endtask : t_registers

    // common memory: every lane mode written and read back
    task automatic t_common;
        card_op(1'b1, 1'b0, csd_pkg::LANE_WORD, 11'h020, 16'h1122, 1'b0, rd);
        card_op(1'b1, 1'b0, csd_pkg::LANE_LOW, 11'h020, 16'h0033, 1'b0, rd);
        card_op(1'b1, 1'b0, csd_pkg::LANE_HIGH, 11'h020, 16'h0044, 1'b0, rd);
        card_op(1'b0, 1'b0, csd_pkg::LANE_WORD, 11'h020, 16'h0, 1'b0, rd);
        chk("common word", 32'h4433, {16'h0, rd[15:0]});
        card_op(1'b0, 1'b0, csd_pkg::LANE_LOW, 11'h020, 16'h0, 1'b0, rd);
        chk("common low byte", 32'h33, {24'h0, rd[7:0]});
        card_op(1'b0, 1'b0, csd_pkg::LANE_HIGH, 11'h020, 16'h0, 1'b0, rd);
        chk("common high byte", 32'h44, {24'h0, rd[7:0]});
    endtask : t_common

    // the four configuration registers, then a word access to one of them
    task automatic t_config;
        for (int i = 0; i < 4; i++) begin
            card_op(1'b1, 1'b1, csd_pkg::LANE_LOW, 11'h200 + 11'(2 * i), 16'(8'h10 + i), 1'b0, rd);
        end
        for (int i = 0; i < 4; i++) begin
            card_op(1'b0, 1'b1, csd_pkg::LANE_LOW, 11'h200 + 11'(2 * i), 16'h0, 1'b0, rd);
            chk("config register", 32'(8'h10 + i), {24'h0, rd[7:0]});
        end
        card_op(1'b1, 1'b1, csd_pkg::LANE_WORD, 11'h202, 16'hee77, 1'b0, rd);
        card_op(1'b0, 1'b1, csd_pkg::LANE_WORD, 11'h202, 16'h0, 1'b0, rd);
        chk("word attribute low byte", 32'h77, {24'h0, rd[7:0]});
    endtask : t_config

    // card info bytes come back on the low lane, byte and word reads alike
    task automatic t_cis;
        card_op(1'b0, 1'b1, csd_pkg::LANE_LOW, 11'h006, 16'h0, 1'b0, rd);
        chk("card info byte", 32'(8'h03 ^ 8'ha5), {24'h0, rd[7:0]});
        card_op(1'b0, 1'b1, csd_pkg::LANE_WORD, 11'h00a, 16'h0, 1'b0, rd);
        chk("card info word", 32'(8'h05 ^ 8'ha5), {24'h0, rd[7:0]});
    endtask : t_cis

    // refused accesses leave the stored register untouched
    task automatic t_refuse;
        card_op(1'b1, 1'b1, csd_pkg::LANE_LOW, 11'h004, 16'h0099, 1'b1, rd);
        card_op(1'b1, 1'b1, csd_pkg::LANE_WORD, 11'h004, 16'h0099, 1'b1, rd);
        card_op(1'b0, 1'b1, csd_pkg::LANE_LOW, 11'h203, 16'h0, 1'b1, rd);
        card_op(1'b1, 1'b1, csd_pkg::LANE_LOW, 11'h203, 16'h0099, 1'b1, rd);
        card_op(1'b1, 1'b1, csd_pkg::LANE_HIGH, 11'h202, 16'h0099, 1'b1, rd);
        card_op(1'b1, 1'b1, csd_pkg::LANE_LOW, 11'h210, 16'h0099, 1'b1, rd);
        card_op(1'b1, 1'b0, csd_pkg::LANE_NONE, 11'h020, 16'h0099, 1'b1, rd);
        card_op(1'b0, 1'b1, csd_pkg::LANE_LOW, 11'h202, 16'h0, 1'b0, rd);
        chk("register after refusals", 32'h77, {24'h0, rd[7:0]});
    endtask : t_refuse

    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_registers();
        t_common();
        t_config();
        t_cis();
        t_refuse();
        print_verdict();
    end
endmodule : tb
